// File: rtl/serial_wake_break_sync_tx.sv
// serial port: wake on edge, break send/receive, synchronous master transmit
//
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module serial_wake_break_sync_tx (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic [3:0] addr_i,
	input wire logic [7:0] wr_data_i,
	input wire logic wr_en_i,
	input wire logic rd_en_i,
	output logic [7:0] rd_data_o,
	input wire logic receive_data_line_i,
	output logic receive_data_line_o,
	output logic receive_data_line_oe_o,
	output logic transmit_pin_o,
	output logic transmit_pin_oe_o
);
	// control bits
	logic clock_source_master_ff;
	logic ninth_bit_transmit_enable_ff;
	logic transmit_enable_bit_ff;
	logic sync_mode_ff;
	logic send_break_request_ff;
	logic ninth_transmit_bit_ff;
	logic data_polarity_select_ff;
	logic clock_polarity_select_ff;
	logic wake_on_edge_enable_ff;
	logic auto_baud_enable_ff;
	logic port_enable_ff;
	logic receive_enable_ff;
	logic [15:0] divisor_ff;
	// transmit path
	logic [7:0] transmit_buffer_ff;
	logic buffer_full_ff;
	logic [13:0] transmit_shifter_ff;
	logic [3:0] bits_left_ff;
	logic shifter_busy_ff;
	logic half_phase_ff;
	logic break_frame_ff;
	logic line_bit_ff;
	logic [13:0] nxt_pattern;
	logic [3:0] nxt_length;
	logic load_shifter;
	logic frame_done;
	logic tx_tick;
	// receive path
	serial_port_pkg::rx_state_type rx_state_ff;
	logic [16:0] rx_count_ff;
	logic [3:0] rx_index_ff;
	logic [7:0] rx_shift_ff;
	logic [7:0] receive_buffer_ff;
	logic receive_flag_ff;
	logic rx_level;
	logic rx_rise;
	logic rx_fall;
	logic rx_value;
	logic start_edge;
	logic can_receive;
	logic rx_sample;
	logic rx_byte_done;
	logic wake_event;
	logic wake_clear;
	// bus and pins
	logic [7:0] rd_data_ff;
	logic tx_pin_ff;
	logic tx_pin_oe_ff;
	logic data_line_ff;
	logic data_line_oe_ff;
	logic sync_master;
	logic wr_tsc;
	logic wr_bcr;
	logic wr_txb;
	logic rd_rxb;

	assign wr_tsc = wr_en_i && (addr_i == serial_port_pkg::ADDR_TRANSMIT_STATUS_CONTROL);
	assign wr_bcr = wr_en_i && (addr_i == serial_port_pkg::ADDR_BAUD_CONTROL_REGISTER);
	assign wr_txb = wr_en_i && (addr_i == serial_port_pkg::ADDR_TRANSMIT_BUFFER);
	assign rd_rxb = rd_en_i && (addr_i == serial_port_pkg::ADDR_RECEIVE_BUFFER);
	assign sync_master = port_enable_ff && sync_mode_ff && clock_source_master_ff;

	// transmit_status_control; send-break clears after the break stop bit
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			clock_source_master_ff <= 1'b0;
			ninth_bit_transmit_enable_ff <= 1'b0;
			transmit_enable_bit_ff <= 1'b0;
			sync_mode_ff <= 1'b0;
			send_break_request_ff <= 1'b0;
			ninth_transmit_bit_ff <= 1'b0;
		end else if (wr_tsc) begin
			clock_source_master_ff <= wr_data_i[serial_port_pkg::TSC_CLOCK_SOURCE_MASTER];
			ninth_bit_transmit_enable_ff <=
				wr_data_i[serial_port_pkg::TSC_NINTH_BIT_TRANSMIT_ENABLE];
			transmit_enable_bit_ff <= wr_data_i[serial_port_pkg::TSC_TRANSMIT_ENABLE_BIT];
			sync_mode_ff <= wr_data_i[serial_port_pkg::TSC_SYNC_MODE];
			send_break_request_ff <= wr_data_i[serial_port_pkg::TSC_SEND_BREAK_REQUEST];
			ninth_transmit_bit_ff <= wr_data_i[serial_port_pkg::TSC_NINTH_TRANSMIT_BIT];
		end else if (frame_done && break_frame_ff) begin
			send_break_request_ff <= 1'b0;
		end
	end

	// baud_control_register; wake enable cleared by the rising edge after wake
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			data_polarity_select_ff <= 1'b0;
			clock_polarity_select_ff <= 1'b0;
			wake_on_edge_enable_ff <= 1'b0;
			auto_baud_enable_ff <= 1'b0;
		end else if (wr_bcr) begin
			data_polarity_select_ff <= wr_data_i[serial_port_pkg::BCR_DATA_POLARITY_SELECT];
			clock_polarity_select_ff <= wr_data_i[serial_port_pkg::BCR_CLOCK_POLARITY_SELECT];
			wake_on_edge_enable_ff <= wr_data_i[serial_port_pkg::BCR_WAKE_ON_EDGE_ENABLE];
			auto_baud_enable_ff <= wr_data_i[serial_port_pkg::BCR_AUTO_BAUD_ENABLE];
		end else if (wake_clear) begin
			wake_on_edge_enable_ff <= 1'b0;
		end
	end

	// receive control and baud divisor
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			port_enable_ff <= 1'b0;
			receive_enable_ff <= 1'b0;
			divisor_ff <= serial_port_pkg::DIVISOR_RST;
		end else if (wr_en_i) begin
			if (addr_i == serial_port_pkg::ADDR_RECEIVE_CONTROL) begin
				port_enable_ff <= wr_data_i[serial_port_pkg::RCS_PORT_ENABLE];
				receive_enable_ff <= wr_data_i[serial_port_pkg::RCS_RECEIVE_ENABLE];
			end
			if (addr_i == serial_port_pkg::ADDR_DIVISOR_LOW) begin
				divisor_ff[7:0] <= wr_data_i;
			end
			if (addr_i == serial_port_pkg::ADDR_DIVISOR_HIGH) begin
				divisor_ff[15:8] <= wr_data_i;
			end
		end
	end

	// transmit buffer; a write on the load cycle refills it at once
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			transmit_buffer_ff <= serial_port_pkg::BYTE_RST;
			buffer_full_ff <= 1'b0;
		end else if (wr_txb) begin
			transmit_buffer_ff <= wr_data_i;
			buffer_full_ff <= 1'b1;
		end else if (load_shifter) begin
			buffer_full_ff <= 1'b0;
		end
	end

	// frame image, lowest bit first
	always_comb begin
		if (sync_mode_ff) begin
			nxt_pattern = {5'h00, ninth_transmit_bit_ff, transmit_buffer_ff};
			nxt_length = ninth_bit_transmit_enable_ff ? serial_port_pkg::SYNC9_FRAME_BITS
				: serial_port_pkg::SYNC8_FRAME_BITS;
		end else if (send_break_request_ff) begin
			nxt_pattern = {1'b1, 13'h0000};
			nxt_length = serial_port_pkg::BREAK_FRAME_BITS;
		end else if (ninth_bit_transmit_enable_ff) begin
			nxt_pattern = {3'h0, 1'b1, ninth_transmit_bit_ff, transmit_buffer_ff, 1'b0};
			nxt_length = serial_port_pkg::ASYNC9_FRAME_BITS;
		end else begin
			nxt_pattern = {4'h0, 1'b1, transmit_buffer_ff, 1'b0};
			nxt_length = serial_port_pkg::ASYNC8_FRAME_BITS;
		end
	end

	assign load_shifter = !shifter_busy_ff && buffer_full_ff && transmit_enable_bit_ff
		&& port_enable_ff && !(sync_mode_ff && (rx_state_ff == serial_port_pkg::RX_DATA));
	assign frame_done = shifter_busy_ff && tx_tick && half_phase_ff
		&& (bits_left_ff == 4'h0);

	half_bit_tick u_half_bit_tick (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.run_i(shifter_busy_ff),
		.divisor_i(divisor_ff),
		.tick_o(tx_tick)
	);

	// each bit lasts two half-bit ticks; it changes when the clock leaves idle
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			transmit_shifter_ff <= 14'h0000;
			bits_left_ff <= 4'h0;
			shifter_busy_ff <= 1'b0;
			half_phase_ff <= 1'b0;
			break_frame_ff <= 1'b0;
			line_bit_ff <= 1'b1;
		end else if (load_shifter) begin
			transmit_shifter_ff <= nxt_pattern;
			bits_left_ff <= nxt_length;
			shifter_busy_ff <= 1'b1;
			half_phase_ff <= 1'b0;
			break_frame_ff <= send_break_request_ff && !sync_mode_ff;
		end else if (shifter_busy_ff && tx_tick) begin
			if (!half_phase_ff) begin
				line_bit_ff <= transmit_shifter_ff[0];
				transmit_shifter_ff <= {1'b0, transmit_shifter_ff[13:1]};
				bits_left_ff <= bits_left_ff - 4'h1;
				half_phase_ff <= 1'b1;
			end else begin
				half_phase_ff <= 1'b0;
				if (bits_left_ff == 4'h0) begin
					shifter_busy_ff <= 1'b0;
					break_frame_ff <= 1'b0;
				end
			end
		end else if (!shifter_busy_ff) begin
			line_bit_ff <= !sync_mode_ff;
		end
	end

	// pins: async line, or master clock and data
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			tx_pin_ff <= 1'b1;
			tx_pin_oe_ff <= 1'b0;
			data_line_ff <= 1'b0;
			data_line_oe_ff <= 1'b0;
		end else if (!port_enable_ff) begin
			tx_pin_ff <= 1'b1;
			tx_pin_oe_ff <= 1'b0;
			data_line_ff <= 1'b0;
			data_line_oe_ff <= 1'b0;
		end else if (sync_master) begin
			tx_pin_ff <= clock_polarity_select_ff ^ (shifter_busy_ff && half_phase_ff);
			tx_pin_oe_ff <= 1'b1;
			data_line_ff <= data_polarity_select_ff ^ line_bit_ff;
			data_line_oe_ff <= transmit_enable_bit_ff;
		end else begin
			tx_pin_ff <= clock_polarity_select_ff ^ line_bit_ff;
			tx_pin_oe_ff <= 1'b1;
			data_line_ff <= 1'b0;
			data_line_oe_ff <= 1'b0;
		end
	end

	line_sync u_line_sync (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.pin_i(receive_data_line_i),
		.level_o(rx_level),
		.rise_o(rx_rise),
		.fall_o(rx_fall)
	);

	assign rx_value = rx_level ^ data_polarity_select_ff;
	assign start_edge = data_polarity_select_ff ? rx_rise : rx_fall;
	// no async reception in sync mode or while wake is armed
	assign can_receive = port_enable_ff && receive_enable_ff && !sync_mode_ff
		&& !wake_on_edge_enable_ff;
	assign wake_event = (rx_state_ff == serial_port_pkg::RX_IDLE) && wake_on_edge_enable_ff
		&& rx_fall;
	assign wake_clear = (rx_state_ff == serial_port_pkg::RX_WAKE_WAIT) && rx_rise;
	assign rx_sample = (rx_state_ff == serial_port_pkg::RX_DATA) && (rx_count_ff == 17'h0_0000);
	assign rx_byte_done = rx_sample && (rx_index_ff == serial_port_pkg::RX_STOP_INDEX);

	// receiver: idle, wake wait, or bit sampling at mid-bit
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			rx_state_ff <= serial_port_pkg::RX_IDLE;
			rx_count_ff <= 17'h0_0000;
			rx_index_ff <= 4'h0;
			rx_shift_ff <= serial_port_pkg::BYTE_RST;
		end else begin
			case (rx_state_ff)
				serial_port_pkg::RX_IDLE: begin
					if (wake_event) begin
						rx_state_ff <= serial_port_pkg::RX_WAKE_WAIT;
					end else if (can_receive && start_edge) begin
						rx_state_ff <= serial_port_pkg::RX_DATA;
						rx_count_ff <= {1'b0, divisor_ff};
						rx_index_ff <= 4'h0;
					end
				end
				serial_port_pkg::RX_WAKE_WAIT: begin
					if (rx_rise || !wake_on_edge_enable_ff) begin
						rx_state_ff <= serial_port_pkg::RX_IDLE;
					end
				end
				serial_port_pkg::RX_DATA: begin
					if (rx_count_ff != 17'h0_0000) begin
						rx_count_ff <= rx_count_ff - 17'h0_0001;
					end else begin
						rx_count_ff <= {divisor_ff, 1'b1};
						rx_index_ff <= rx_index_ff + 4'h1;
						if ((rx_index_ff == 4'h0) && rx_value) begin
							rx_state_ff <= serial_port_pkg::RX_IDLE;
						end else if (rx_index_ff == serial_port_pkg::RX_STOP_INDEX) begin
							rx_state_ff <= serial_port_pkg::RX_IDLE;
						end else if (rx_index_ff != 4'h0) begin
							rx_shift_ff <= {rx_value, rx_shift_ff[7:1]};
						end
					end
				end
				default: begin
					rx_state_ff <= serial_port_pkg::RX_IDLE;
				end
			endcase
		end
	end

	// receive buffer and flag; a set in the read cycle wins
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			receive_buffer_ff <= serial_port_pkg::BYTE_RST;
			receive_flag_ff <= 1'b0;
		end else if (wake_event) begin
			receive_flag_ff <= 1'b1;
		end else if (rx_byte_done) begin
			receive_buffer_ff <= rx_shift_ff;
			receive_flag_ff <= 1'b1;
		end else if (rd_rxb) begin
			receive_flag_ff <= 1'b0;
		end
	end

	// read data stands only in the cycle after the read strobe
	always_ff @(posedge core_clk_i) begin
		if (rst_i || !rd_en_i) begin
			rd_data_ff <= serial_port_pkg::BYTE_RST;
		end else begin
			case (addr_i)
				serial_port_pkg::ADDR_TRANSMIT_STATUS_CONTROL: begin
					rd_data_ff <= {clock_source_master_ff, ninth_bit_transmit_enable_ff,
						transmit_enable_bit_ff, sync_mode_ff, send_break_request_ff, 1'b0,
						!shifter_busy_ff, ninth_transmit_bit_ff};
				end
				serial_port_pkg::ADDR_BAUD_CONTROL_REGISTER: begin
					rd_data_ff <= {1'b0, rx_state_ff != serial_port_pkg::RX_DATA,
						data_polarity_select_ff, clock_polarity_select_ff, 2'b00,
						wake_on_edge_enable_ff, auto_baud_enable_ff};
				end
				serial_port_pkg::ADDR_RECEIVE_CONTROL: begin
					rd_data_ff <= {port_enable_ff, 2'b00, receive_enable_ff, 4'h0};
				end
				serial_port_pkg::ADDR_RECEIVE_BUFFER: begin
					rd_data_ff <= receive_buffer_ff;
				end
				serial_port_pkg::ADDR_DIVISOR_LOW: begin
					rd_data_ff <= divisor_ff[7:0];
				end
				serial_port_pkg::ADDR_DIVISOR_HIGH: begin
					rd_data_ff <= divisor_ff[15:8];
				end
				serial_port_pkg::ADDR_EVENT_FLAGS: begin
					rd_data_ff <= {6'h00, !buffer_full_ff, receive_flag_ff};
				end
				default: begin
					rd_data_ff <= serial_port_pkg::BYTE_RST;
				end
			endcase
		end
	end

	assign rd_data_o = rd_data_ff;
	assign transmit_pin_o = tx_pin_ff;
	assign transmit_pin_oe_o = tx_pin_oe_ff;
	assign receive_data_line_o = data_line_ff;
	assign receive_data_line_oe_o = data_line_oe_ff;
endmodule : serial_wake_break_sync_tx

// File: rtl/serial_port_pkg.sv
// constants shared by the serial wake, break and synchronous transmit block
package serial_port_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;
	localparam int DIV_W = 16;
	localparam int FRAME_W = 14;
	localparam int COUNT_W = 4;
	// register offsets
	localparam logic [3:0] ADDR_TRANSMIT_STATUS_CONTROL = 4'h0;
	localparam logic [3:0] ADDR_BAUD_CONTROL_REGISTER = 4'h1;
	localparam logic [3:0] ADDR_RECEIVE_CONTROL = 4'h2;
	localparam logic [3:0] ADDR_TRANSMIT_BUFFER = 4'h3;
	localparam logic [3:0] ADDR_RECEIVE_BUFFER = 4'h4;
	localparam logic [3:0] ADDR_DIVISOR_LOW = 4'h5;
	localparam logic [3:0] ADDR_DIVISOR_HIGH = 4'h6;
	localparam logic [3:0] ADDR_EVENT_FLAGS = 4'h7;
	// transmit_status_control fields
	localparam int TSC_CLOCK_SOURCE_MASTER = 7;
	localparam int TSC_NINTH_BIT_TRANSMIT_ENABLE = 6;
	localparam int TSC_TRANSMIT_ENABLE_BIT = 5;
	localparam int TSC_SYNC_MODE = 4;
	localparam int TSC_SEND_BREAK_REQUEST = 3;
	localparam int TSC_SHIFTER_EMPTY_FLAG = 1;
	localparam int TSC_NINTH_TRANSMIT_BIT = 0;
	// baud_control_register fields
	localparam int BCR_RECEIVE_IDLE_FLAG = 6;
	localparam int BCR_DATA_POLARITY_SELECT = 5;
	localparam int BCR_CLOCK_POLARITY_SELECT = 4;
	localparam int BCR_WAKE_ON_EDGE_ENABLE = 1;
	localparam int BCR_AUTO_BAUD_ENABLE = 0;
	// receive control and event flag fields
	localparam int RCS_PORT_ENABLE = 7;
	localparam int RCS_RECEIVE_ENABLE = 4;
	localparam int EVF_TRANSMIT_BUFFER_EMPTY_FLAG = 1;
	localparam int EVF_RECEIVE_FLAG = 0;
	// reset values
	localparam logic [15:0] DIVISOR_RST = 16'h0000;
	localparam logic [7:0] BYTE_RST = 8'h00;
	// frame lengths in bits, and the receive stop-bit index
	localparam logic [3:0] BREAK_FRAME_BITS = 4'hE;
	localparam logic [3:0] ASYNC9_FRAME_BITS = 4'hB;
	localparam logic [3:0] ASYNC8_FRAME_BITS = 4'hA;
	localparam logic [3:0] SYNC9_FRAME_BITS = 4'h9;
	localparam logic [3:0] SYNC8_FRAME_BITS = 4'h8;
	localparam logic [3:0] RX_STOP_INDEX = 4'h9;
	typedef enum logic [1:0] {
		RX_IDLE = 2'b00,
		RX_WAKE_WAIT = 2'b01,
		RX_DATA = 2'b10
	} rx_state_type;
endpackage : serial_port_pkg

// File: rtl/half_bit_tick.sv
// divider giving one-cycle half-bit ticks while enabled
`timescale 1ns/1ps
module half_bit_tick (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic run_i,
	input wire logic [15:0] divisor_i,
	output logic tick_o
);
	logic [15:0] count_ff;
	logic tick_ff;

	// a tick every divisor+1 cycles, restarting when run falls
	always_ff @(posedge core_clk_i) begin
		if (rst_i || !run_i) begin
			count_ff <= serial_port_pkg::DIVISOR_RST;
			tick_ff <= 1'b0;
		end else if (count_ff == divisor_i) begin
			count_ff <= serial_port_pkg::DIVISOR_RST;
			tick_ff <= 1'b1;
		end else begin
			count_ff <= count_ff + 16'h0001;
			tick_ff <= 1'b0;
		end
	end

	assign tick_o = tick_ff;
endmodule : half_bit_tick

// File: rtl/line_sync.sv
// two-flop synchroniser for a pin with registered edge pulses
`timescale 1ns/1ps
module line_sync (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic pin_i,
	output logic level_o,
	output logic rise_o,
	output logic fall_o
);
	logic meta_ff;
	logic level_ff;
	logic prev_ff;
	logic rise_ff;
	logic fall_ff;

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			meta_ff <= 1'b1;
			level_ff <= 1'b1;
			prev_ff <= 1'b1;
			rise_ff <= 1'b0;
			fall_ff <= 1'b0;
		end else begin
			meta_ff <= pin_i;
			level_ff <= meta_ff;
			prev_ff <= level_ff;
			rise_ff <= level_ff && !prev_ff;
			fall_ff <= !level_ff && prev_ff;
		end
	end

	assign level_o = prev_ff;
	assign rise_o = rise_ff;
	assign fall_o = fall_ff;
endmodule : line_sync

// File: dv/serial_port_assertions.sv
// port-level assertions for the serial wake, break and sync transmit block
`timescale 1ns/1ps
module serial_port_assertions (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic [3:0] addr_i,
	input wire logic [7:0] wr_data_i,
	input wire logic wr_en_i,
	input wire logic rd_en_i,
	input wire logic [7:0] rd_data_o,
	input wire logic receive_data_line_i,
	input wire logic receive_data_line_o,
	input wire logic receive_data_line_oe_o,
	input wire logic transmit_pin_o,
	input wire logic transmit_pin_oe_o
);
	logic [7:0] tsc_ff, bcr_ff, rcs_ff;
	logic [15:0] div_ff, run_ff;
	logic [3:0] age_ff;
	logic last_ff, rxq_ff, txw_ff, rose_ff, sm, ok;
	assign sm = tsc_ff[7] && tsc_ff[4] && rcs_ff[7];
	assign ok = age_ff == 4'hF;
	// shadow of written settings, aged so the output lag after a change is skipped
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			tsc_ff <= 8'h00;
			bcr_ff <= 8'h00;
			rcs_ff <= 8'h00;
			div_ff <= 16'h0000;
			age_ff <= 4'h0;
		end else if (wr_en_i && addr_i != 4'h3) begin
			age_ff <= 4'h0;
			case (addr_i)
				4'h0: tsc_ff <= wr_data_i;
				4'h1: bcr_ff <= wr_data_i;
				4'h2: rcs_ff <= wr_data_i;
				4'h5: div_ff[7:0] <= wr_data_i;
				4'h6: div_ff[15:8] <= wr_data_i;
				default: ;
			endcase
		end else if (!ok) begin
			age_ff <= age_ff + 4'h1;
		end
	end
	// length of the level that the transmit pin held up to the previous cycle
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			last_ff <= 1'b1;
			run_ff <= 16'h0000;
		end else begin
			last_ff <= transmit_pin_o;
			if (transmit_pin_o != last_ff) run_ff <= 16'h0001;
			else if (run_ff != 16'hFFFF) run_ff <= run_ff + 16'h0001;
		end
	end
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			rxq_ff <= 1'b1;
			txw_ff <= 1'b0;
			rose_ff <= 1'b0;
		end else begin
			rxq_ff <= receive_data_line_i;
			if (wr_en_i && addr_i == 4'h3) txw_ff <= 1'b1;
			if (wr_en_i && addr_i == 4'h1) rose_ff <= 1'b0;
			else if (receive_data_line_i && !rxq_ff) rose_ff <= 1'b1;
		end
	end
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	property p_pin_en;
		ok |-> transmit_pin_oe_o == rcs_ff[7];
	endproperty
	a_pin_en: assert property (p_pin_en) else $error("pin enable wrong");
	property p_data_en;
		ok && receive_data_line_oe_o |-> sm;
	endproperty
	a_data_en: assert property (p_data_en) else $error("data driven off mode");
	property p_clk_idle;
		ok && sm && run_ff > div_ff + 16'h0002 |-> last_ff == bcr_ff[4];
	endproperty
	a_clk_idle: assert property (p_clk_idle) else $error("clock idle level");
	property p_data_idle;
		ok && sm && receive_data_line_oe_o && run_ff > {div_ff[14:0], 1'b0} + 16'h0004
			|-> receive_data_line_o == bcr_ff[5];
	endproperty
	a_data_idle: assert property (p_data_idle) else $error("data idle level");
	property p_half_period;
		ok && sm && transmit_pin_o != last_ff |-> run_ff > div_ff;
	endproperty
	a_half_period: assert property (p_half_period) else $error("clock too fast");
	property p_break_len;
		ok && !tsc_ff[4] && !bcr_ff[4] && transmit_pin_o && !last_ff
			|-> run_ff <= (div_ff + 16'h0001) * 16'h001A;
	endproperty
	a_break_len: assert property (p_break_len) else $error("low run too long");
	property p_tbe_reset;
		rd_en_i && addr_i == 4'h7 && !txw_ff |=> rd_data_o[1];
	endproperty
	a_tbe_reset: assert property (p_tbe_reset) else $error("empty flag lost");
	property p_wake_hold;
		rd_en_i && addr_i == 4'h1 && bcr_ff[1] && !rose_ff |=> rd_data_o[1];
	endproperty
	a_wake_hold: assert property (p_wake_hold) else $error("wake bit dropped");
endmodule : serial_port_assertions

bind serial_wake_break_sync_tx serial_port_assertions checker_inst (
	.core_clk_i(core_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
	.wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .rd_data_o(rd_data_o),
	.receive_data_line_i(receive_data_line_i), .receive_data_line_o(receive_data_line_o),
	.receive_data_line_oe_o(receive_data_line_oe_o), .transmit_pin_o(transmit_pin_o),
	.transmit_pin_oe_o(transmit_pin_oe_o)
);

// File: dv/serial_peer.sv
// serial peer: drives the receive line and captures synchronous data
`timescale 1ns/1ps
module serial_peer (
	input wire logic core_clk_i,
	input wire logic clk_line_i,
	input wire logic data_line_i,
	input wire logic clk_idle_i,
	output logic line_o,
	output logic line_en_o,
	output logic [15:0] cap_o,
	output logic [4:0] nbits_o
);
	localparam int BIT_CYC = 16;
	logic clk_q = 1'b0;
	initial begin
		line_o = 1'b1;
		line_en_o = 1'b0;
		cap_o = 16'h0000;
		nbits_o = 5'h00;
	end
	always @(posedge core_clk_i) begin
		if (clk_line_i === clk_idle_i && clk_q !== clk_idle_i) begin
			cap_o <= {data_line_i, cap_o[15:1]};
			nbits_o <= nbits_o + 5'h01;
		end
		clk_q <= clk_line_i;
	end
	task clear;
		cap_o = 16'h0000;
		nbits_o = 5'h00;
	endtask : clear
	task drive(input logic lvl);
		@(posedge core_clk_i);
		line_en_o <= 1'b1;
		line_o <= lvl;
	endtask : drive
	// start, eight bits lsb first, stop
	task send(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			drive(f[i]);
			repeat (BIT_CYC - 1) @(posedge core_clk_i);
		end
	endtask : send
endmodule : serial_peer

// File: dv/tb_top.sv
// self-checking bench for the serial wake, break and sync transmit block
`timescale 1ns/1ps
module tb_top;
	logic core_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [3:0] addr_i = 4'h0;
	logic [7:0] wr_data_i = 8'h00;
	logic wr_en_i = 1'b0;
	logic rd_en_i = 1'b0;
	logic ckp = 1'b0;
	logic [7:0] rd_data_o, rv;
	logic d_o, d_oe, tx_o, tx_oe, line, p_line, p_en, tx_q;
	logic [15:0] cap;
	logic [4:0] nbits;
	int num_errors = 0;
	int n_tests = 0;
	int cyc = 0;
	int run_len = 0;
	int runs[$];
	always #2 core_clk_i = ~core_clk_i;
	// pulled up when nobody drives it
	assign line = d_oe ? d_o : (p_en ? p_line : 1'b1);
	serial_wake_break_sync_tx uut (
		.core_clk_i(core_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
		.wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .rd_data_o(rd_data_o),
		.receive_data_line_i(line), .receive_data_line_o(d_o),
		.receive_data_line_oe_o(d_oe), .transmit_pin_o(tx_o), .transmit_pin_oe_o(tx_oe)
	);
	serial_peer peer (
		.core_clk_i(core_clk_i), .clk_line_i(tx_o), .data_line_i(line), .clk_idle_i(ckp),
		.line_o(p_line), .line_en_o(p_en), .cap_o(cap), .nbits_o(nbits)
	);
	// run lengths of the transmit pin, sampled away from the launching edge
	always @(negedge core_clk_i) begin
		if (tx_o !== tx_q) begin
			runs.push_back(run_len);
			run_len = 1;
		end else begin
			run_len++;
		end
		tx_q = tx_o;
	end
	always @(posedge core_clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			results();
		end
	end
	task chk(input logic [23:0] got, input logic [23:0] exp);
		n_tests++;
		if (got !== exp) begin
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
			num_errors++;
		end
	endtask : chk
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge core_clk_i);
		addr_i <= a;
		wr_data_i <= d;
		wr_en_i <= 1'b1;
		@(posedge core_clk_i);
		wr_en_i <= 1'b0;
	endtask : wr
	task rd(input logic [3:0] a);
		@(posedge core_clk_i);
		addr_i <= a;
		rd_en_i <= 1'b1;
		@(posedge core_clk_i);
		rd_en_i <= 1'b0;
		#1;
		rv = rd_data_o;
	endtask : rd
	task rdchk(input logic [3:0] a, input logic [7:0] exp);
		rd(a);
		chk(rv, exp);
	endtask : rdchk
	task poll(input logic [3:0] a, input logic [7:0] m, input logic [7:0] v);
		int n;
		n = 0;
		rd(a);
		while ((rv & m) !== v && n < 500) begin
			rd(a);
			n++;
		end
		chk(rv & m, v);
	endtask : poll
	task t_reset;
		rdchk(4'h0, 8'h02);
		wr(4'h7, 8'h00);
		rdchk(4'h7, 8'h02);
		rdchk(4'h8, 8'h00);
	endtask : t_reset
	task t_sync;
		wr(4'h5, 8'h00);
		wr(4'h6, 8'h00);
		wr(4'h2, 8'h80);
		wr(4'h1, 8'h20);
		wr(4'h0, 8'hB0);
		repeat (4) @(posedge core_clk_i);
		#1;
		chk({tx_oe, tx_o, d_o}, 3'b101);
		ckp <= 1'b1;
		wr(4'h1, 8'h10);
		repeat (4) @(posedge core_clk_i);
		#1;
		chk({tx_o, d_o}, 2'b10);
		peer.clear();
		wr(4'h3, 8'hA5);
		wr(4'h3, 8'h3C);
		rdchk(4'h7, 8'h00);
		poll(4'h0, 8'h02, 8'h02);
		rdchk(4'h7, 8'h02);
		chk({nbits, cap}, {5'h10, 16'h3CA5});
		wr(4'h0, 8'hF1);
		peer.clear();
		wr(4'h3, 8'h96);
		poll(4'h0, 8'h02, 8'h02);
		chk({nbits, cap}, {5'h09, 16'hCB00});
	endtask : t_sync
	task t_break;
		ckp <= 1'b0;
		wr(4'h0, 8'h00);
		wr(4'h1, 8'h00);
		wr(4'h5, 8'h07);
		wr(4'h0, 8'h28);
		runs.delete();
		wr(4'h3, 8'hFF);
		wr(4'h3, 8'h55);
		rdchk(4'h0, 8'h28);
		poll(4'h0, 8'h0A, 8'h02);
		chk(runs[1], 208);
		chk(runs[2] >= 16 && runs[2] <= 19, 1'b1);
		chk(runs[3], 16);
	endtask : t_break
	task t_wake;
		wr(4'h2, 8'h90);
		rdchk(4'h1, 8'h40);
		wr(4'h1, 8'h02);
		peer.drive(1'b0);
		repeat (8) @(posedge core_clk_i);
		rdchk(4'h7, 8'h03);
		rd(4'h4);
		rdchk(4'h7, 8'h02);
		repeat (200) @(posedge core_clk_i);
		rdchk(4'h1, 8'h42);
		rdchk(4'h7, 8'h02);
		peer.drive(1'b1);
		repeat (8) @(posedge core_clk_i);
		rdchk(4'h1, 8'h40);
		peer.send(8'h5A);
		poll(4'h7, 8'h01, 8'h01);
		rdchk(4'h4, 8'h5A);
		wr(4'h5, 8'h0A);
		peer.drive(1'b0);
		repeat (207) @(posedge core_clk_i);
		peer.drive(1'b1);
		poll(4'h7, 8'h01, 8'h01);
		rdchk(4'h4, 8'h00);
	endtask : t_wake
	task results;
		$display("errors %0d checks %0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : results
	initial begin
		repeat (4) @(posedge core_clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_sync();
		t_break();
		t_wake();
		results();
	end
endmodule : tb_top
